// ### dac_input_defines.svh
// constants for the converter input latch and sleep control
`ifndef DAC_INPUT_DEFINES_SVH
`define DAC_INPUT_DEFINES_SVH
`define SAMPLE_WIDTH       12
`define SAMPLE_ZERO        12'h000
`define SAMPLE_FULL        12'hFFF
`define CLK_PERIOD_PS      4000
`define WAKE_TIME_US       3250
`define WAKE_CYCLES        ((`WAKE_TIME_US * 1000) / (`CLK_PERIOD_PS / 1000))
`define SLEEP_TIME_NS      5000
`define SLEEP_CYCLES       ((`SLEEP_TIME_NS * 1000) / `CLK_PERIOD_PS)
`endif

// ### dac_input_pkg.sv
// types for the converter input latch and sleep control
package dac_input_pkg;
  typedef struct packed {
    logic [11:0] trueLevel;
    logic [11:0] complementLevel;
  } output_pair_t;
  typedef enum logic [1:0] {
    ACTIVE,
    ASLEEP,
    WAKING
  } power_state_t;
endpackage

// ### dac_parallel_input_latch_sleep.sv
// input latch, complementary output code and sleep control of the converter
`timescale 1ns/100ps
`include "dac_input_defines.svh"
module dac_parallel_input_latch_sleep #(
  parameter int WAKE_CYCLES = `WAKE_CYCLES
) (
  // clock and reset
  input  wire logic                             sys_clk,
  input  wire logic                             sys_rst,
  // sample word from the driving logic
  input  wire logic [`SAMPLE_WIDTH-1:0]         sampleWord,
  // power-down pin, floating when not driven
  input  wire logic                             powerDownPin,
  input  wire logic                             powerDownDriven,
  // current steering outputs
  output dac_input_pkg::output_pair_t           currentLevels,
  output logic                                  outputEnabled,
  output logic                                  outputSettled
);
  typedef logic [31:0] count_t;

  logic [`SAMPLE_WIDTH-1:0]     sampleMaster_q;
  dac_input_pkg::output_pair_t  levels_q;
  logic                         pinMeta_q;
  logic                         pinSync_q;
  logic                         drvMeta_q;
  logic                         drvSync_q;
  logic                         pdSync;
  logic                         pdLevel;
  dac_input_pkg::power_state_t  state_q;
  count_t                       wakeCount_q;

  function automatic dac_input_pkg::output_pair_t split_code(
    input logic [`SAMPLE_WIDTH-1:0] code,
    input logic                     on
  );
    dac_input_pkg::output_pair_t r;
    r.trueLevel       = on ? code : `SAMPLE_ZERO;
    r.complementLevel = on ? (`SAMPLE_FULL - code) : `SAMPLE_ZERO;
    return r;
  endfunction

  // raw pin level, watched by the checks only
  assign pdLevel = powerDownDriven & powerDownPin;

  // both pins synchronised before they are combined
  always_ff @(posedge sys_clk) begin
    pinMeta_q <= powerDownPin;
    pinSync_q <= pinMeta_q;
    drvMeta_q <= powerDownDriven;
    drvSync_q <= drvMeta_q;
  end

  // floating pin reads as low
  assign pdSync = pinSync_q & drvSync_q;

  // master stage: edge captured, no reset
  always_ff @(posedge sys_clk) begin
    sampleMaster_q <= sampleWord;
  end

  // slave stage drives current outputs after each rising edge
  always_ff @(posedge sys_clk) begin
    levels_q <= split_code(sampleMaster_q, !pdSync);
  end

  // power state, level sensitive
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q     <= dac_input_pkg::ACTIVE;
      wakeCount_q <= '0;
    end else begin
      case (state_q)
        dac_input_pkg::ACTIVE: begin
          if (pdSync) begin
            state_q <= dac_input_pkg::ASLEEP;
          end
        end
        dac_input_pkg::ASLEEP: begin
          if (!pdSync) begin
            state_q     <= dac_input_pkg::WAKING;
            wakeCount_q <= '0;
          end
        end
        dac_input_pkg::WAKING: begin
          if (pdSync) begin
            state_q <= dac_input_pkg::ASLEEP;
          end else if (wakeCount_q == count_t'(WAKE_CYCLES - 1)) begin
            state_q <= dac_input_pkg::ACTIVE;
          end else begin
            wakeCount_q <= wakeCount_q + count_t'(1);
          end
        end
        default: state_q <= dac_input_pkg::ACTIVE;
      endcase
    end
  end

  assign currentLevels = levels_q;
  assign outputEnabled = !pdSync;
  assign outputSettled = (state_q == dac_input_pkg::ACTIVE) && !pdSync;

  property p_complement;
    @(posedge sys_clk) disable iff (sys_rst)
      !$past(pdSync) |->
        (levels_q.trueLevel + levels_q.complementLevel == `SAMPLE_FULL);
  endproperty
  a_complement: assert property (p_complement)
    else $error("outputs do not sum to full scale");

  property p_latency;
    @(posedge sys_clk) disable iff (sys_rst)
      (!pdSync [*3]) |-> levels_q.trueLevel == $past(sampleWord, 2);
  endproperty
  a_latency: assert property (p_latency)
    else $error("true output does not follow latched word");

  property p_sleep_off;
    @(posedge sys_clk) disable iff (sys_rst)
      pdSync |=> levels_q.trueLevel == `SAMPLE_ZERO
                   && levels_q.complementLevel == `SAMPLE_ZERO;
  endproperty
  a_sleep_off: assert property (p_sleep_off)
    else $error("current flows while asleep");

  property p_float_enabled;
    @(posedge sys_clk) disable iff (sys_rst)
      (!powerDownDriven [*3]) |-> outputEnabled;
  endproperty
  a_float_enabled: assert property (p_float_enabled)
    else $error("floating power-down input disabled output");

  property p_capture;
    @(posedge sys_clk) disable iff (sys_rst)
      $stable(sampleWord) |=> $stable(sampleMaster_q);
  endproperty
  a_capture: assert property (p_capture)
    else $error("latch changed without new input word");

  property p_wake_not_early;
    @(posedge sys_clk) disable iff (sys_rst)
      (state_q == dac_input_pkg::WAKING) |-> !outputSettled;
  endproperty
  a_wake_not_early: assert property (p_wake_not_early)
    else $error("settled before wake time elapsed");

  property p_sleep_entry;
    @(posedge sys_clk) disable iff (sys_rst)
      $rose(pdLevel) ##1 pdLevel |=> ##[0:1] !outputEnabled;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry)
    else $error("power-down not honoured in time");

  property p_msb;
    @(posedge sys_clk) disable iff (sys_rst)
      (!pdSync [*3]) ##0 $past(sampleWord[`SAMPLE_WIDTH-1], 2)
        |-> levels_q.trueLevel[`SAMPLE_WIDTH-1];
  endproperty
  a_msb: assert property (p_msb)
    else $error("top sample bit not carried to output");

  property p_lsb;
    @(posedge sys_clk) disable iff (sys_rst)
      (!pdSync [*3]) ##0 $past(sampleWord[0], 2)
        |-> levels_q.trueLevel[0];
  endproperty
  a_lsb: assert property (p_lsb)
    else $error("bottom sample bit not carried to output");

  property p_full_scale;
    @(posedge sys_clk) disable iff (sys_rst)
      (!pdSync [*3]) ##0 ($past(sampleWord, 2) == `SAMPLE_FULL)
        |-> levels_q.trueLevel == `SAMPLE_FULL
            && levels_q.complementLevel == `SAMPLE_ZERO;
  endproperty
  a_full_scale: assert property (p_full_scale)
    else $error("all ones word not at full scale");

  property p_zero_code;
    @(posedge sys_clk) disable iff (sys_rst)
      (!pdSync [*3]) ##0 ($past(sampleWord, 2) == `SAMPLE_ZERO)
        |-> levels_q.trueLevel == `SAMPLE_ZERO
            && levels_q.complementLevel == `SAMPLE_FULL;
  endproperty
  a_zero_code: assert property (p_zero_code)
    else $error("zero word does not steer all to complement");

  property p_capture_edge;
    @(posedge sys_clk) disable iff (sys_rst)
      !$stable(sampleWord) |=> sampleMaster_q == $past(sampleWord);
  endproperty
  a_capture_edge: assert property (p_capture_edge)
    else $error("new word not captured at the clock edge");

  property p_sleep_state;
    @(posedge sys_clk) disable iff (sys_rst)
      (state_q == dac_input_pkg::ACTIVE) && pdSync
        |=> state_q == dac_input_pkg::ASLEEP;
  endproperty
  a_sleep_state: assert property (p_sleep_state)
    else $error("sleep level did not enter sleep state");

  property p_wake_enable;
    @(posedge sys_clk) disable iff (sys_rst)
      $fell(pdLevel) ##1 !pdLevel |=> ##[0:1] outputEnabled;
  endproperty
  a_wake_enable: assert property (p_wake_enable)
    else $error("current not restored after power-down released");

  property p_wake_start;
    @(posedge sys_clk) disable iff (sys_rst)
      (state_q == dac_input_pkg::ASLEEP) && !pdSync
        |=> state_q == dac_input_pkg::WAKING && wakeCount_q == '0;
  endproperty
  a_wake_start: assert property (p_wake_start)
    else $error("wake count did not start from zero");

  property p_wake_done;
    @(posedge sys_clk) disable iff (sys_rst)
      (state_q == dac_input_pkg::WAKING) && !pdSync
        && wakeCount_q == count_t'(WAKE_CYCLES - 1) |=> outputSettled;
  endproperty
  a_wake_done: assert property (p_wake_done)
    else $error("output not settled when wake time ran out");
endmodule

// ### word_source.sv
// driving logic model: sample word and power-down pin
`timescale 1ns/100ps
module word_source (
  // clock shared with the converter
  input  wire logic        sys_clk,
  // requests from the bench
  input  wire logic        sleepReq,
  input  wire logic        floatPin,
  input  wire logic [11:0] nextWord,
  // pins toward the converter
  output logic [11:0]      sampleWord,
  output logic             powerDownPin,
  output logic             powerDownDriven
);
  // data moves on the falling edge, away from the latch edge
  always_ff @(negedge sys_clk) begin
    sampleWord <= nextWord;
  end
  // undriven pin falls to its pull-down level
  // no external control amplifier fitted, so sleep is allowed
  assign powerDownPin = floatPin ? 1'b0 : sleepReq;
  assign powerDownDriven = !floatPin;
endmodule

// ### dac_parallel_input_latch_sleep_tb.sv
// self-checking bench for the converter input latch
`timescale 1ns/100ps
module dac_parallel_input_latch_sleep_tb;
  localparam int WAKE = 8;
  logic                        sys_clk, sys_rst, sleepReq, floatPin;
  logic [11:0]                 nextWord, sampleWord;
  logic                        powerDownPin, powerDownDriven;
  logic                        outputEnabled, outputSettled;
  dac_input_pkg::output_pair_t currentLevels;
  int                          num_errors = 0;
  int                          n_tests = 0;
  dac_parallel_input_latch_sleep #(.WAKE_CYCLES(WAKE)) dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .sampleWord(sampleWord),
    .powerDownPin(powerDownPin), .powerDownDriven(powerDownDriven),
    .currentLevels(currentLevels), .outputEnabled(outputEnabled),
    .outputSettled(outputSettled));
  word_source src (.sys_clk(sys_clk), .sleepReq(sleepReq), .floatPin(floatPin),
    .nextWord(nextWord), .sampleWord(sampleWord),
    .powerDownPin(powerDownPin), .powerDownDriven(powerDownDriven));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task conclude;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic step(input logic [11:0] w, input logic s, input logic f);
    @(posedge sys_clk);
    nextWord <= w;
    sleepReq <= s;
    floatPin <= f;
    #1;
  endtask
  task automatic waitEn(input logic v);
    int i;
    for (i = 0; i < 20 && outputEnabled !== v; i++) step(nextWord, sleepReq, 0);
    if (i == 20) begin
      num_errors++;
      conclude();
    end
  endtask
  task automatic dataRun;
    logic [11:0] w[6] = '{12'h000, 12'hFFF, 12'h800, 12'h001, 12'hFFE, 12'h7FF};
    for (int i = 0; i < 9; i++) begin
      step(w[i%6], 0, 0);
      if (i >= 2) chk(currentLevels, {w[(i-2)%6], 12'hFFF - w[(i-2)%6]});
    end
  endtask
  task automatic sleepRun;
    int n;
    step(12'h555, 1, 0);
    waitEn(0);
    step(12'h3C3, 1, 0);
    chk(currentLevels, 24'h00_0000);
    chk(outputSettled, 0);
    step(12'h123, 0, 0);
    for (n = 1; n < 40 && outputSettled !== 1'b1; n++) step(12'h123, 0, 0);
    chk({n >= WAKE, n <= WAKE + 6}, 2'b11);
    chk(outputEnabled, 1);
    chk(currentLevels, {12'h123, 12'hEDC});
  endtask
  task automatic floatRun;
    repeat (5) step(12'h0F0, 0, 1);
    chk(outputEnabled, 1);
    chk(currentLevels, {12'h0F0, 12'hF0F});
  endtask
  initial begin
    sys_rst = 1'b1;
    nextWord = 12'h000;
    sleepReq = 1'b0;
    floatPin = 1'b0;
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    dataRun();
    sleepRun();
    floatRun();
    conclude();
  end
endmodule
